/* logic/ucps_top.sv */
// Cell port slice: UTOPIA cell paths, MII receive status, serial DMA number
//
// Behaviour
// - Slave start-of-cell marks first cell byte
// - Slave cell available when full cell held
// - Eight-bit transmit bus, bit zero LSB
// - Idle cells fill master transmit gaps; cells 53 bytes
// - Six-bit module number, low five sub-block
// - Bit five: transmit zero, receive one
// - Module number captured on transfer error
// - Receive bus valid only after enable cycle
`timescale 1ns/100ps
`default_nettype none

module ucps_afifo #(
    parameter int W = 8
) (
    input  wire logic         wclk,
    input  wire logic         wrst,
    input  wire logic         w_valid,
    input  wire logic [W-1:0] w_data,
    output var  logic         w_ready,
    input  wire logic         rclk,
    input  wire logic         rrst,
    output var  logic         r_valid,
    output logic      [W-1:0] r_data,
    input  wire logic         r_pop
);
    // Two entries with gray pointers; ready and valid lag the far side, never overstate
    logic [W-1:0] mem [2];
    logic [1:0]   wbin_reg, wgray_reg, rq1_reg, rq2_reg;
    logic [1:0]   rbin_reg, rgray_reg, wq1_reg, wq2_reg;
    logic         w_ready_reg, r_valid_reg;
    wire  logic   push = w_valid && w_ready_reg;
    wire  logic   pop  = r_pop && r_valid_reg;
    wire  logic [1:0] wbin_next = wbin_reg + {1'b0, push};
    wire  logic [1:0] rbin_next = rbin_reg + {1'b0, pop};

    assign w_ready = w_ready_reg;
    assign r_valid = r_valid_reg;
    assign r_data  = mem[rbin_reg[0]];

    always_ff @(posedge wclk) begin
        if (push) begin
            mem[wbin_reg[0]] <= w_data;
        end
    end

    always_ff @(posedge wclk) begin
        if (wrst) begin
            wbin_reg    <= ucps_pkg::FIFO_PTR_RST;
            wgray_reg   <= ucps_pkg::FIFO_PTR_RST;
            rq1_reg     <= ucps_pkg::FIFO_PTR_RST;
            rq2_reg     <= ucps_pkg::FIFO_PTR_RST;
            w_ready_reg <= 1'b0;
        end else begin
            wbin_reg    <= wbin_next;
            wgray_reg   <= ucps_pkg::bin2gray(wbin_next);
            rq1_reg     <= rgray_reg;
            rq2_reg     <= rq1_reg;
            w_ready_reg <= (wbin_next - ucps_pkg::gray2bin(rq2_reg)) != ucps_pkg::FIFO_FULL_CNT;
        end
    end

    always_ff @(posedge rclk) begin
        if (rrst) begin
            rbin_reg    <= ucps_pkg::FIFO_PTR_RST;
            rgray_reg   <= ucps_pkg::FIFO_PTR_RST;
            wq1_reg     <= ucps_pkg::FIFO_PTR_RST;
            wq2_reg     <= ucps_pkg::FIFO_PTR_RST;
            r_valid_reg <= 1'b0;
        end else begin
            rbin_reg    <= rbin_next;
            rgray_reg   <= ucps_pkg::bin2gray(rbin_next);
            wq1_reg     <= wgray_reg;
            wq2_reg     <= wq1_reg;
            r_valid_reg <= rbin_next != ucps_pkg::gray2bin(wq2_reg);
        end
    end
endmodule // ucps_afifo

module ucps_top (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       link_clk,
    input  wire logic [2:0] mode,
    input  wire logic       tx_byte_valid,
    input  wire logic [7:0] tx_byte_data,
    output var  logic       tx_byte_ready,
    output logic            rx_byte_valid,
    output logic      [7:0] rx_byte_data,
    output logic            rx_byte_sop,
    input  wire logic       rx_byte_ready,
    output logic      [7:0] utx_data,
    output logic            utx_soc,
    output logic            utx_enb_n,
    output logic            utx_oe,
    input  wire logic       utx_clav,
    input  wire logic [7:0] urx_data_in,
    input  wire logic       urx_soc_in,
    output logic      [7:0] urx_data_out,
    output logic            urx_soc_out,
    output logic            urx_data_oe,
    input  wire logic       urx_enb_n_in,
    output logic            urx_enb_n_out,
    output logic            urx_enb_oe,
    input  wire logic       urx_clav_in,
    output logic            urx_clav_out,
    output logic            urx_clav_oe,
    input  wire logic       polled_phy0_rx_cell_avail,
    input  wire logic       mii_crs,
    input  wire logic       mii_rx_dv,
    input  wire logic       mii_rx_er,
    output logic            mii_data_valid,
    output logic            mii_broken_header,
    output logic            mii_rx_error,
    input  wire logic       dma_active,
    input  wire logic [4:0] dma_sub_block,
    input  wire logic       dma_rx_section,
    input  wire logic       dma_xfer_error,
    input  wire logic       dma_err_clear,
    output logic      [5:0] dma_module_number,
    output logic            dma_module_number_oe,
    output logic      [5:0] dma_err_module_number,
    output logic            dma_err_valid
);
    // ---------------- Link clock domain ----------------
    logic       lrst_s1_reg, lrst_reg;
    logic [2:0] lmode_s1_reg, lmode_s2_reg;
    logic [7:0] cell_mem [ucps_pkg::CELL_BYTES];
    logic [5:0] fill_cnt_reg, pos_reg;
    logic       cell_full_reg, in_cell_reg, data_cell_reg;
    logic [7:0] utx_data_reg, urx_data_out_reg;
    logic       utx_soc_reg, utx_enb_n_reg, utx_oe_reg;
    logic       urx_soc_out_reg, urx_data_oe_reg, urx_clav_out_reg, urx_clav_oe_reg;
    logic       urx_enb_n_reg, sample_reg, urx_enb_oe_reg;
    logic       txq_valid, rxq_ready, rxq_valid, rx_load, rx_valid_reg;
    logic [7:0] txq_data;
    logic [8:0] rxq_data;

    wire ucps_pkg::ucps_mode_e lmode = ucps_pkg::ucps_mode_e'(lmode_s2_reg);
    wire logic is_master = (lmode == ucps_pkg::UCPS_MODE_UT_MASTER)
                        || (lmode == ucps_pkg::UCPS_MODE_UT_POLL);
    wire logic is_slave  = lmode == ucps_pkg::UCPS_MODE_UT_SLAVE;
    // Polling mode listens to PHY zero's dedicated line, else the shared one
    wire logic clav_sel  = (lmode == ucps_pkg::UCPS_MODE_UT_POLL) ?
                           polled_phy0_rx_cell_avail : urx_clav_in;
    wire logic fill_go   = (is_master || is_slave) && !cell_full_reg && txq_valid;
    wire logic fill_last = fill_cnt_reg == ucps_pkg::CELL_LAST;
    wire logic emit_m    = is_master && (in_cell_reg || utx_clav);
    wire logic emit_s    = is_slave && !urx_enb_n_in && (in_cell_reg || cell_full_reg);
    wire logic emit      = emit_m || emit_s;
    wire logic [5:0] idx = in_cell_reg ? pos_reg : ucps_pkg::CELL_FIRST;
    wire logic is_data   = in_cell_reg ? data_cell_reg : cell_full_reg;
    wire logic emit_last = idx == ucps_pkg::CELL_LAST;
    // In master mode, no queued cell at a boundary means an idle cell goes out instead
    wire logic [7:0] emit_byte = is_data ? cell_mem[idx] : ucps_pkg::IDLE_BYTE;
    wire logic enb_go    = is_master && clav_sel && rxq_ready && urx_enb_n_reg && !sample_reg;

    // Reset and mode reach the link side through two flops; mode is static configuration
    always_ff @(posedge link_clk) begin
        lrst_s1_reg  <= rst;
        lrst_reg     <= lrst_s1_reg;
        lmode_s1_reg <= mode;
        lmode_s2_reg <= lmode_s1_reg;
    end

    always_ff @(posedge link_clk) begin
        if (fill_go) begin
            cell_mem[fill_cnt_reg] <= txq_data;
        end
    end

    // Cell store fills byte by byte; it empties only after its last byte leaves
    always_ff @(posedge link_clk) begin
        if (lrst_reg) begin
            fill_cnt_reg  <= ucps_pkg::CELL_FIRST;
            cell_full_reg <= 1'b0;
        end else if (fill_go) begin
            fill_cnt_reg  <= fill_last ? ucps_pkg::CELL_FIRST : fill_cnt_reg + 6'h01;
            cell_full_reg <= fill_last;
        end else if (emit && emit_last && is_data) begin
            cell_full_reg <= 1'b0;
        end
    end

    always_ff @(posedge link_clk) begin
        if (lrst_reg) begin
            pos_reg       <= ucps_pkg::CELL_FIRST;
            in_cell_reg   <= 1'b0;
            data_cell_reg <= 1'b0;
        end else if (emit) begin
            pos_reg       <= emit_last ? ucps_pkg::CELL_FIRST : idx + 6'h01;
            in_cell_reg   <= !emit_last;
            data_cell_reg <= is_data;
        end else if (!(is_master || is_slave)) begin
            in_cell_reg   <= 1'b0;
        end
    end

    // Master transmit: a cell, once started, runs all 53 bytes without pause
    always_ff @(posedge link_clk) begin
        if (lrst_reg) begin
            utx_data_reg  <= ucps_pkg::IDLE_BYTE;
            utx_soc_reg   <= 1'b0;
            utx_enb_n_reg <= 1'b1;
            utx_oe_reg    <= 1'b0;
        end else begin
            utx_data_reg  <= emit_m ? emit_byte : ucps_pkg::IDLE_BYTE;
            utx_soc_reg   <= emit_m && (idx == ucps_pkg::CELL_FIRST);
            utx_enb_n_reg <= !emit_m;
            utx_oe_reg    <= is_master;
        end
    end

    // Slave receive: bus driven in the cycle after the master's enable
    always_ff @(posedge link_clk) begin
        if (lrst_reg) begin
            urx_data_out_reg <= ucps_pkg::IDLE_BYTE;
            urx_soc_out_reg  <= 1'b0;
            urx_data_oe_reg  <= 1'b0;
            urx_clav_out_reg <= 1'b0;
            urx_clav_oe_reg  <= 1'b0;
        end else begin
            urx_data_out_reg <= emit_s ? emit_byte : ucps_pkg::IDLE_BYTE;
            urx_soc_out_reg  <= emit_s && (idx == ucps_pkg::CELL_FIRST);
            urx_data_oe_reg  <= emit_s;
            urx_clav_out_reg <= is_slave && cell_full_reg && !in_cell_reg;
            urx_clav_oe_reg  <= is_slave;
        end
    end

    // Master receive: one enable, then two dead cycles, so the two-entry buffer never overruns
    always_ff @(posedge link_clk) begin
        if (lrst_reg) begin
            urx_enb_n_reg  <= 1'b1;
            sample_reg     <= 1'b0;
            urx_enb_oe_reg <= 1'b0;
        end else begin
            urx_enb_n_reg  <= !enb_go;
            sample_reg     <= !urx_enb_n_reg;
            urx_enb_oe_reg <= is_master;
        end
    end

    ucps_afifo #(.W(8)) u_txq (
        .wclk    (clk),
        .wrst    (rst),
        .w_valid (tx_byte_valid),
        .w_data  (tx_byte_data),
        .w_ready (tx_byte_ready),
        .rclk    (link_clk),
        .rrst    (lrst_reg),
        .r_valid (txq_valid),
        .r_data  (txq_data),
        .r_pop   (fill_go)
    );

    ucps_afifo #(.W(9)) u_rxq (
        .wclk    (link_clk),
        .wrst    (lrst_reg),
        .w_valid (sample_reg),
        .w_data  ({urx_soc_in, urx_data_in}),
        .w_ready (rxq_ready),
        .rclk    (clk),
        .rrst    (rst),
        .r_valid (rxq_valid),
        .r_data  (rxq_data),
        .r_pop   (rx_load)
    );

    // ---------------- System clock domain ----------------
    logic       rx_sop_reg;
    logic [7:0] rx_data_reg;
    logic [2:0] mii_s1_reg, mii_s2_reg, mii_s3_reg, mii_st_reg;
    logic       mii_dv_reg, mii_bh_reg, mii_er_reg;
    logic [5:0] dma_num_reg, dma_err_num_reg;
    logic       dma_oe_reg, dma_err_valid_reg;

    wire ucps_pkg::ucps_mode_e smode = ucps_pkg::ucps_mode_e'(mode);
    wire logic is_mii   = smode == ucps_pkg::UCPS_MODE_MII;
    wire logic is_dma   = smode == ucps_pkg::UCPS_MODE_DMA_NUM;
    assign rx_load = rxq_valid && (!rx_valid_reg || rx_byte_ready);
    wire logic [2:0] mii_agree = ~(mii_s2_reg ^ mii_s3_reg);
    wire logic [5:0] dma_num_now = {dma_rx_section, dma_sub_block};

    always_ff @(posedge clk) begin
        if (rst) begin
            rx_valid_reg <= 1'b0;
            rx_sop_reg   <= 1'b0;
            rx_data_reg  <= ucps_pkg::IDLE_BYTE;
        end else if (rx_load) begin
            rx_valid_reg <= 1'b1;
            rx_sop_reg   <= rxq_data[ucps_pkg::BYTE_W];
            rx_data_reg  <= rxq_data[ucps_pkg::BYTE_W-1:0];
        end else if (rx_byte_ready) begin
            rx_valid_reg <= 1'b0;
        end
    end

    // MII status pins come from the PHY clock: three flops, change taken when two agree
    always_ff @(posedge clk) begin
        if (rst) begin
            mii_s1_reg <= 3'h0;
            mii_s2_reg <= 3'h0;
            mii_s3_reg <= 3'h0;
            mii_st_reg <= 3'h0;
        end else begin
            mii_s1_reg <= {mii_rx_er, mii_rx_dv, mii_crs};
            mii_s2_reg <= mii_s1_reg;
            mii_s3_reg <= mii_s2_reg;
            mii_st_reg <= (mii_agree & mii_s2_reg) | (~mii_agree & mii_st_reg);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mii_dv_reg <= 1'b0;
            mii_bh_reg <= 1'b0;
            mii_er_reg <= 1'b0;
        end else begin
            mii_dv_reg <= is_mii && mii_st_reg[1];
            mii_bh_reg <= is_mii && mii_st_reg[0] && !mii_st_reg[1];
            mii_er_reg <= is_mii && mii_st_reg[2];
        end
    end

    // Error capture: a new error in the clearing cycle keeps the flag set
    always_ff @(posedge clk) begin
        if (rst) begin
            dma_num_reg       <= ucps_pkg::DMA_NUM_RST;
            dma_oe_reg        <= 1'b0;
            dma_err_num_reg   <= ucps_pkg::DMA_NUM_RST;
            dma_err_valid_reg <= 1'b0;
        end else begin
            dma_num_reg       <= (is_dma && dma_active) ? dma_num_now : ucps_pkg::DMA_NUM_RST;
            dma_oe_reg        <= is_dma;
            dma_err_valid_reg <= dma_xfer_error || (dma_err_valid_reg && !dma_err_clear);
            if (dma_xfer_error) begin
                dma_err_num_reg <= dma_num_now;
            end
        end
    end

    assign utx_data              = utx_data_reg;
    assign utx_soc               = utx_soc_reg;
    assign utx_enb_n             = utx_enb_n_reg;
    assign utx_oe                = utx_oe_reg;
    assign urx_data_out          = urx_data_out_reg;
    assign urx_soc_out           = urx_soc_out_reg;
    assign urx_data_oe           = urx_data_oe_reg;
    assign urx_enb_n_out         = urx_enb_n_reg;
    assign urx_enb_oe            = urx_enb_oe_reg;
    assign urx_clav_out          = urx_clav_out_reg;
    assign urx_clav_oe           = urx_clav_oe_reg;
    assign rx_byte_valid         = rx_valid_reg;
    assign rx_byte_data          = rx_data_reg;
    assign rx_byte_sop           = rx_sop_reg;
    assign mii_data_valid        = mii_dv_reg;
    assign mii_broken_header     = mii_bh_reg;
    assign mii_rx_error          = mii_er_reg;
    assign dma_module_number     = dma_num_reg;
    assign dma_module_number_oe  = dma_oe_reg;
    assign dma_err_module_number = dma_err_num_reg;
    assign dma_err_valid         = dma_err_valid_reg;
endmodule // ucps_top

`default_nettype wire

/* logic/ucps_pkg.sv */
// Shared constants, mode type and pointer helpers for the cell port slice
package ucps_pkg;
    typedef enum logic [2:0] {
        UCPS_MODE_OFF,
        UCPS_MODE_UT_MASTER,
        UCPS_MODE_UT_POLL,
        UCPS_MODE_UT_SLAVE,
        UCPS_MODE_MII,
        UCPS_MODE_DMA_NUM
    } ucps_mode_e;

    localparam int          BYTE_W         = 8;
    localparam int          CELL_BYTES     = 53;
    localparam logic [5:0]  CELL_FIRST     = 6'h00;
    localparam logic [5:0]  CELL_LAST      = 6'(CELL_BYTES - 1);
    localparam logic [7:0]  IDLE_BYTE      = 8'h00;
    localparam int          DMA_SECT_BIT   = 5;
    localparam logic        DMA_SECT_TX    = 1'b0;
    localparam logic        DMA_SECT_RX    = 1'b1;
    localparam logic [5:0]  DMA_NUM_RST    = 6'h00;
    localparam logic [1:0]  FIFO_PTR_RST   = 2'h0;
    localparam logic [1:0]  FIFO_FULL_CNT  = 2'h2;
    localparam logic [2:0]  MODE_RST       = 3'h0;

    function automatic logic [1:0] bin2gray(input logic [1:0] b);
        return b ^ {1'b0, b[1]};
    endfunction

    function automatic logic [1:0] gray2bin(input logic [1:0] g);
        return {g[1], g[1] ^ g[0]};
    endfunction
endpackage

/* verif/ucps_chk.sv */
// Concurrent checks on the ports of the cell port slice
`timescale 1ns/100ps
`default_nettype none

module ucps_chk (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       link_clk,
    input wire logic [2:0] mode,
    input wire logic       utx_soc,
    input wire logic       utx_enb_n,
    input wire logic       utx_oe,
    input wire logic       urx_enb_n_in,
    input wire logic       urx_soc_out,
    input wire logic       urx_data_oe,
    input wire logic       urx_enb_oe,
    input wire logic       mii_crs,
    input wire logic       mii_rx_dv,
    input wire logic       mii_rx_er,
    input wire logic       mii_broken_header,
    input wire logic       mii_rx_error,
    input wire logic       dma_active,
    input wire logic [4:0] dma_sub_block,
    input wire logic       dma_rx_section,
    input wire logic       dma_xfer_error,
    input wire logic       dma_err_clear,
    input wire logic [5:0] dma_module_number,
    input wire logic [5:0] dma_err_module_number,
    input wire logic       dma_err_valid
);
    logic [5:0] byte_idx_reg;
    wire  [5:0] byte_idx_next = utx_soc ? 6'h01 : byte_idx_reg + 6'h01;
    wire        dma_on = mode == ucps_pkg::UCPS_MODE_DMA_NUM && dma_active;
    wire        mii_on = mode == ucps_pkg::UCPS_MODE_MII;
    wire        master = mode == ucps_pkg::UCPS_MODE_UT_MASTER
                         || mode == ucps_pkg::UCPS_MODE_UT_POLL;

    // Bytes since the last start of cell; 53 means a cell just ended
    always_ff @(posedge link_clk) begin
        if (rst)
            byte_idx_reg <= 6'h00;
        else if (!utx_enb_n && utx_oe)
            byte_idx_reg <= byte_idx_next;
    end

    sequence crs_only_s;
        (mii_on && mii_crs && !mii_rx_dv) [*6];
    endsequence
    sequence rx_err_s;
        (mii_on && mii_rx_er) [*6];
    endsequence

    cell_len_a: assert property (@(posedge link_clk) disable iff (rst)
        !utx_enb_n && utx_oe |-> (utx_soc ? (byte_idx_reg == 6'h00 || byte_idx_reg == 6'h35)
            : (byte_idx_reg != 6'h00 && byte_idx_reg < 6'h35))) else $error("cell length");
    slave_drive_a: assert property (@(posedge link_clk) disable iff (rst)
        urx_data_oe |-> !$past(urx_enb_n_in)) else $error("slave drive without enable");
    slave_soc_a: assert property (@(posedge link_clk) disable iff (rst)
        urx_soc_out |-> urx_data_oe) else $error("start of cell off bus");
    dma_number_a: assert property (@(posedge clk) disable iff (rst)
        dma_on |=> dma_module_number == {$past(dma_rx_section), $past(dma_sub_block)})
        else $error("module number");
    dma_quiet_a: assert property (@(posedge clk) disable iff (rst)
        !dma_on |=> dma_module_number == 6'h00) else $error("module number while idle");
    err_capture_a: assert property (@(posedge clk) disable iff (rst)
        dma_xfer_error |=> dma_err_valid
            && dma_err_module_number == {$past(dma_rx_section), $past(dma_sub_block)})
        else $error("error capture");
    err_clear_a: assert property (@(posedge clk) disable iff (rst)
        dma_err_clear && !dma_xfer_error |=> !dma_err_valid) else $error("error clear");
    broken_hdr_a: assert property (@(posedge clk) disable iff (rst)
        crs_only_s |-> mii_broken_header) else $error("broken header missed");
    rx_error_a: assert property (@(posedge clk) disable iff (rst)
        rx_err_s |-> mii_rx_error) else $error("receive error missed");
    mode_pins_a: assert property (@(posedge clk) disable iff (rst)
        !master |-> !utx_oe && !urx_enb_oe && (mii_on || !mii_broken_header && !mii_rx_error))
        else $error("pin used outside its mode");
endmodule // ucps_chk

bind ucps_top ucps_chk ucps_chk_inst (
    .clk, .rst, .link_clk, .mode, .utx_soc, .utx_enb_n, .utx_oe, .urx_enb_n_in,
    .urx_soc_out, .urx_data_oe, .urx_enb_oe, .mii_crs, .mii_rx_dv, .mii_rx_er,
    .mii_broken_header, .mii_rx_error, .dma_active, .dma_sub_block, .dma_rx_section,
    .dma_xfer_error, .dma_err_clear, .dma_module_number, .dma_err_module_number,
    .dma_err_valid
);

`default_nettype wire

/* verif/ucps_phy_model.sv */
// Behavioural UTOPIA PHY facing the cell port slice
`timescale 1ns/100ps
`default_nettype none

module ucps_phy_model (
    input  wire logic       link_clk,
    input  wire logic       accept,
    input  wire logic       src_on,
    input  wire logic       poll,
    input  wire logic       slv_on,
    input  wire logic       urx_enb_n_out,
    output logic            utx_clav,
    output logic      [7:0] urx_data_in,
    output logic            urx_soc_in,
    output logic            urx_clav_in,
    output logic            polled_phy0_rx_cell_avail,
    output logic            urx_enb_n_in
);
    logic [5:0] src_idx = 6'h00;
    logic       pace = 1'b0;
    wire        has_cell = src_on && src_idx < 6'h35;

    assign utx_clav = accept;
    assign urx_clav_in = has_cell && !poll;
    assign polled_phy0_rx_cell_avail = has_cell && poll;

    initial begin
        urx_data_in = 8'h00;
        urx_soc_in = 1'b0;
        urx_enb_n_in = 1'b1;
    end

    // As master in slave mode, enable every other cycle to force pauses
    always @(posedge link_clk) begin
        pace <= !pace;
        urx_enb_n_in <= !(slv_on && pace);
        if (!src_on)
            src_idx <= 6'h00;
        if (src_on && !urx_enb_n_out) begin
            urx_data_in <= 8'h40 + 8'(src_idx);
            urx_soc_in <= src_idx == 6'h00;
            src_idx <= src_idx + 6'h01;
        end else begin
            // Released bus never repeats the previous cycle's byte
            urx_data_in <= ~urx_data_in;
            urx_soc_in <= ~urx_soc_in;
        end
    end
endmodule // ucps_phy_model

`default_nettype wire

/* verif/ucps_tb_top.sv */
// Self-checking bench for the cell port slice
`timescale 1ns/100ps
`default_nettype none

module ucps_tb_top;
    logic        clk = 1'b0;
    logic        link_clk = 1'b0;
    logic        rst = 1'b1;
    logic        is_data = 1'b0;
    logic [2:0]  mode = 3'h0;
    logic        tx_byte_valid, rx_byte_ready, accept, src_on, poll, slv_on, mii_crs;
    logic        mii_rx_dv, mii_rx_er, dma_active, dma_rx_section, dma_xfer_error;
    logic        dma_err_clear, tx_byte_ready, rx_byte_valid, rx_byte_sop, utx_soc;
    logic        utx_enb_n, utx_oe, utx_clav, urx_soc_in, urx_soc_out, urx_data_oe;
    logic        urx_enb_n_in, urx_enb_n_out, urx_enb_oe, urx_clav_in, urx_clav_out;
    logic        urx_clav_oe, polled_phy0_rx_cell_avail, mii_data_valid, mii_broken_header;
    logic        mii_rx_error, dma_module_number_oe, dma_err_valid;
    logic [4:0]  dma_sub_block;
    logic [5:0]  dma_module_number, dma_err_module_number;
    logic [7:0]  tx_byte_data, rx_byte_data, utx_data, urx_data_in, urx_data_out;
    int          failures = 0, n_checks = 0, cycles = 0, pos = 0, spos = 0, n_cells = 0;
    // Rows: active, section, sub-block, expected number
    logic [12:0] dma_rows [5] = '{{2'b10, 5'h15, 6'h15}, {2'b11, 5'h0A, 6'h2A},
                                  {2'b11, 5'h1F, 6'h3F}, {2'b01, 5'h1F, 6'h00},
                                  {2'b10, 5'h00, 6'h00}};

    ucps_top ucps_top_inst (
        .clk, .rst, .link_clk, .mode, .tx_byte_valid, .tx_byte_data, .tx_byte_ready,
        .rx_byte_valid, .rx_byte_data, .rx_byte_sop, .rx_byte_ready, .utx_data, .utx_soc,
        .utx_enb_n, .utx_oe, .utx_clav, .urx_data_in, .urx_soc_in, .urx_data_out,
        .urx_soc_out, .urx_data_oe, .urx_enb_n_in, .urx_enb_n_out, .urx_enb_oe,
        .urx_clav_in, .urx_clav_out, .urx_clav_oe, .polled_phy0_rx_cell_avail, .mii_crs,
        .mii_rx_dv, .mii_rx_er, .mii_data_valid, .mii_broken_header, .mii_rx_error,
        .dma_active, .dma_sub_block, .dma_rx_section, .dma_xfer_error, .dma_err_clear,
        .dma_module_number, .dma_module_number_oe, .dma_err_module_number, .dma_err_valid
    );
    ucps_phy_model ucps_phy_model_inst (
        .link_clk, .accept, .src_on, .poll, .slv_on, .urx_enb_n_out, .utx_clav,
        .urx_data_in, .urx_soc_in, .urx_clav_in, .polled_phy0_rx_cell_avail, .urx_enb_n_in
    );

    always #25 clk = ~clk;
    // Offset keeps link edges off the bench's drive times
    initial #4 forever #15 link_clk = ~link_clk;

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    task automatic reset_dut(input logic [2:0] m);
        rst = 1'b1;
        {mode, src_on, poll, slv_on} = {m, 3'b000};
        step(5);
        check("reset_state", 8'h01, {6'h00, tx_byte_ready, utx_enb_n});
        rst = 1'b0;
        step(4);
    endtask

    task automatic push_cell();
        for (int i = 0; i < 53; i++) begin
            tx_byte_valid = 1'b1;
            tx_byte_data = 8'h80 + 8'(i);
            @(posedge clk);
            while (tx_byte_ready !== 1'b1) @(posedge clk);
            #2;
        end
        tx_byte_valid = 1'b0;
        step(1);
    endtask

    // Receiver stalls every other cycle
    task automatic pop_cell();
        int i;
        i = 0;
        while (i < 53) begin
            @(posedge clk);
            if (rx_byte_valid === 1'b1 && rx_byte_ready) begin
                check("rx_byte_data", 8'h40 + 8'(i), rx_byte_data);
                check("rx_byte_sop", {7'h00, i == 0}, {7'h00, rx_byte_sop});
                i++;
            end
            #2;
            rx_byte_ready = !rx_byte_ready && i < 53;
        end
    endtask

    always @(posedge link_clk) begin
        if (utx_oe === 1'b1 && utx_enb_n === 1'b0) begin
            if (utx_soc === 1'b1) begin
                pos = 0;
                is_data = utx_data !== ucps_pkg::IDLE_BYTE;
                n_cells = n_cells + int'(is_data);
            end
            check("utx_data", is_data ? 8'h80 + 8'(pos) : ucps_pkg::IDLE_BYTE, utx_data);
            pos++;
        end
        if (urx_data_oe === 1'b1) begin
            check("urx_soc_out", {7'h00, spos == 0}, {7'h00, urx_soc_out});
            check("urx_data_out", 8'h80 + 8'(spos), urx_data_out);
            spos++;
        end
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 10000) begin
            failures++;
            finish_test();
        end
    end

    initial begin
        {tx_byte_valid, rx_byte_ready, accept, src_on, poll, slv_on, mii_crs} = '0;
        {mii_rx_dv, mii_rx_er, dma_active, dma_rx_section, dma_xfer_error, dma_err_clear} = '0;
        {tx_byte_data, dma_sub_block} = '0;
        reset_dut(ucps_pkg::UCPS_MODE_DMA_NUM);
        mii_crs = 1'b1;
        foreach (dma_rows[i]) begin
            {dma_active, dma_rx_section, dma_sub_block} = dma_rows[i][12:6];
            step(2);
            check("dma_module_number", {2'h0, dma_rows[i][5:0]}, {2'h0, dma_module_number});
        end
        check("dma_pins", 8'h01, {6'h00, mii_broken_header, dma_module_number_oe});
        {dma_rx_section, dma_sub_block, dma_xfer_error} = {1'b1, 5'h0C, 1'b1};
        step(1);
        dma_xfer_error = 1'b0;
        step(1);
        check("dma_err", 8'h6C, {1'b0, dma_err_valid, dma_err_module_number});
        {dma_rx_section, dma_sub_block, dma_xfer_error, dma_err_clear} = {1'b0, 5'h03, 2'b11};
        step(1);
        {dma_xfer_error, dma_err_clear} = 2'b00;
        step(1);
        check("dma_err", 8'h43, {1'b0, dma_err_valid, dma_err_module_number});
        dma_err_clear = 1'b1;
        step(1);
        dma_err_clear = 1'b0;
        step(1);
        check("dma_err_valid", 8'h00, {7'h00, dma_err_valid});
        reset_dut(ucps_pkg::UCPS_MODE_MII);
        step(8);
        check("mii_status", 8'h02, {5'h00, mii_data_valid, mii_broken_header, mii_rx_error});
        {mii_rx_dv, mii_rx_er} = 2'b11;
        step(8);
        check("mii_status", 8'h05, {5'h00, mii_data_valid, mii_broken_header, mii_rx_error});
        {mii_crs, mii_rx_dv, mii_rx_er} = 3'b000;
        reset_dut(ucps_pkg::UCPS_MODE_UT_MASTER);
        {accept, src_on} = 2'b11;
        fork
            begin
                push_cell();
                push_cell();
            end
            pop_cell();
            begin
                step(30);
                accept = 1'b0;
                step(40);
                accept = 1'b1;
            end
        join
        step(200);
        check("cells_sent", 8'h02, 8'(n_cells));
        reset_dut(ucps_pkg::UCPS_MODE_UT_POLL);
        {poll, src_on} = 2'b11;
        pop_cell();
        reset_dut(ucps_pkg::UCPS_MODE_UT_SLAVE);
        check("urx_clav_out", 8'h02, {6'h00, urx_clav_oe, urx_clav_out});
        push_cell();
        step(20);
        check("urx_clav_out", 8'h03, {6'h00, urx_clav_oe, urx_clav_out});
        slv_on = 1'b1;
        step(200);
        check("slave_bytes", 8'h35, 8'(spos));
        finish_test();
    end
endmodule // ucps_tb_top

`default_nettype wire
